// >>> pm_pkg.sv
// constants, register map and types of the performance monitor
// assumes a single 10 MHz system clock and a plain word-addressed register port
package pm_pkg;

	// clock and one-second timing
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned SECOND_MS = 1000;
	localparam int unsigned SECOND_CYCLES = SECOND_MS * (CLK_HZ / 1000);

	// classification thresholds
	localparam int unsigned SES_PERCENT = 30;
	localparam int unsigned LINE_SES_LIMIT = 44;
	localparam logic [3:0] PARITY_MAX_PER_FRAME = 4'h8;
	localparam logic [3:0] UNAVAIL_RUN = 4'hA;
	localparam logic [3:0] SES_BACKOUT = 4'h9;
	localparam logic [15:0] PARITY_K_RESET = 16'h0001;

	// field offsets inside one block-based section (mux or regen)
	localparam int F_ES = 0;
	localparam int F_SES = 1;
	localparam int F_UAS = 2;
	localparam int F_BBE = 3;
	localparam int F_EB = 4;
	localparam int F_AVAIL_BLOCKS = 5;
	localparam int F_AVAIL_SECONDS = 6;
	localparam int SEC_FIELDS = 7;

	// counter indices, equal to their word addresses
	localparam int MUX_BASE = 0;
	localparam int REGEN_BASE = 7;
	localparam int LINE_CV = 14;
	localparam int LINE_ES = 15;
	localparam int LINE_SES = 16;
	localparam int LINE_UAS = 17;
	localparam int SECT_CV = 18;
	localparam int SECT_ES = 19;
	localparam int FRAMING_SES = 20;
	localparam int SECT_SES = 21;
	localparam int NUM_COUNTERS = 22;

	// control and status words
	localparam logic [4:0] ADDR_CTRL = 5'h18;
	localparam logic [4:0] ADDR_PARITY_K = 5'h19;
	localparam logic [4:0] ADDR_STATUS = 5'h1A;
	localparam logic [4:0] ADDR_CUR_SECT_CV = 5'h1B;
	localparam logic [4:0] ADDR_CUR_LINE_CV = 5'h1C;
	localparam int CTRL_CLEAR_BIT = 0;

	typedef enum logic [1:0] {
		ST_AVAIL = 2'b01,
		ST_UNAVAIL = 2'b10
	} avail_state_type;

endpackage

// >>> second_tick.sv
// one-second enable pulse divided down from the system clock
// assumes PERIOD of at least one cycle
`timescale 1ns/1ps
`default_nettype none
module second_tick #(
	parameter int unsigned PERIOD = pm_pkg::SECOND_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	output logic tick
);
	logic [31:0] count_q;
	logic at_end;

	assign at_end = (count_q == 32'(PERIOD - 1));
	// one-cycle pulse on the last count of each second
	assign tick = at_end;

	// free-running divider, never stalls
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= 32'h00000000;
		end else if (at_end) begin
			count_q <= 32'h00000000;
		end else begin
			count_q <= count_q + 32'h00000001;
		end
	end
endmodule
`default_nettype wire

// >>> avail_tracker.sv
// availability state of one layer, driven by per-second severity
// assumes tick is a one-cycle pulse and severe is valid in that cycle
`timescale 1ns/1ps
`default_nettype none
module avail_tracker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic severe,
	output logic unavailable,
	output logic entering,
	output logic uas_second
);
	pm_pkg::avail_state_type state_q;
	logic [3:0] run_q;
	logic last_of_run;
	logic leaving;

	// run_q counts qualifying seconds toward a change of state
	assign last_of_run = (run_q == pm_pkg::UNAVAIL_RUN - 4'h1);
	assign entering = tick && (state_q == pm_pkg::ST_AVAIL) && severe && last_of_run;
	assign leaving = tick && (state_q == pm_pkg::ST_UNAVAIL) && !severe && last_of_run;
	// the exit run itself is still unavailable time
	assign uas_second = tick && ((state_q == pm_pkg::ST_UNAVAIL) || entering);
	assign unavailable = (state_q == pm_pkg::ST_UNAVAIL);

	// state changes only on the second boundary
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= pm_pkg::ST_AVAIL;
		end else begin
			case (state_q)
				pm_pkg::ST_AVAIL: begin
					if (entering) begin
						state_q <= pm_pkg::ST_UNAVAIL;
					end
				end
				pm_pkg::ST_UNAVAIL: begin
					if (leaving) begin
						state_q <= pm_pkg::ST_AVAIL;
					end
				end
				default: begin
					state_q <= pm_pkg::ST_AVAIL;
				end
			endcase
		end
	end

	// a second of the opposite kind restarts the run
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 4'h0;
		end else if (tick) begin
			if (entering || leaving) begin
				run_q <= 4'h0;
			end else if ((state_q == pm_pkg::ST_AVAIL) == severe) begin
				run_q <= run_q + 4'h1;
			end else begin
				run_q <= 4'h0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> perf_monitor.sv
// per-second performance accumulation for mux/regen sections and line/section layers
// assumes all inputs synchronous to SYS_CLK; pulses are one cycle per event
//
// Functional notes
// - block with any bit error is errored
// - errored second: errored block or defect
// - severe second: 30% errored blocks or defect
// - background errors only outside severe seconds
// - background ratio counts: blocks outside severe, available
// - errored ratio counts: errored and available seconds
// - severe ratio counts: severe and available seconds
// - mux unavailable after ten severe, leaves after ten
// - entering unavailability moves severe seconds to unavailable
// - regen section has own unavailable tracking
// - line violations sum bipolar and excess zeros
// - parity errors up to eight per frame
// - line errored second: violation or signal loss
// - section errored second: parity, framing, signal loss
// - framing severe second whenever framing defect present
// - section severe: parity at K, framing, loss
// - line unavailable after ten severe seconds
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module perf_monitor #(
	parameter int unsigned SECOND_CYCLES = pm_pkg::SECOND_CYCLES,
	parameter int unsigned BIT_ERR_W = 8
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic MUX_BLOCK_DONE,
	input wire logic [BIT_ERR_W-1:0] MUX_BLOCK_BIT_ERRORS,
	input wire logic MUX_DEFECT,
	input wire logic REGEN_BLOCK_DONE,
	input wire logic [BIT_ERR_W-1:0] REGEN_BLOCK_BIT_ERRORS,
	input wire logic REGEN_DEFECT,
	input wire logic SECTION_FRAME_DONE,
	input wire logic [3:0] SECTION_PARITY_ERRORS,
	input wire logic BIPOLAR_VIOLATION_EVENT,
	input wire logic EXCESS_ZEROS_EVENT,
	input wire logic LOSS_OF_SIGNAL,
	input wire logic SEVERE_FRAMING_DEFECT,
	input wire logic LINE_DEFECT,
	input wire logic [4:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	output logic SECOND_TICK,
	output logic MUX_UNAVAILABLE,
	output logic REGEN_UNAVAILABLE,
	output logic LINE_UNAVAILABLE
);
	localparam int NCNT = pm_pkg::NUM_COUNTERS;
	localparam int NF = pm_pkg::SEC_FIELDS;

	logic tick;
	logic clear_all;
	logic [15:0] parity_k_q;
	logic [31:0] cnt_q [NCNT];
	logic [31:0] cnt_inc [NCNT];
	logic [3:0] cnt_dec [NCNT];

	// per-section inputs gathered for the generate loop
	logic [1:0] blk_done;
	logic [1:0][BIT_ERR_W-1:0] blk_bits;
	logic [1:0] sec_defect;
	logic [1:0][NF-1:0][31:0] sec_inc;
	logic [1:0][NF-1:0][3:0] sec_dec;
	logic [1:0] sec_unavail;

	assign blk_done = {REGEN_BLOCK_DONE, MUX_BLOCK_DONE};
	assign blk_bits = {REGEN_BLOCK_BIT_ERRORS, MUX_BLOCK_BIT_ERRORS};
	assign sec_defect = {REGEN_DEFECT, MUX_DEFECT};

	second_tick #(
		.PERIOD(SECOND_CYCLES)
	) u_tick (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.tick(tick)
	);

	assign SECOND_TICK = tick;

	// software clear is a one-cycle strobe from the control word
	assign clear_all = REG_WR && (REG_ADDR == pm_pkg::ADDR_CTRL) &&
		REG_WDATA[pm_pkg::CTRL_CLEAR_BIT];

	// block-based sections: index 0 is mux, index 1 is regen
	for (genvar s = 0; s < 2; s++) begin : g_sect
		logic [31:0] blocks_q;
		logic [31:0] eb_q;
		logic defect_q;
		logic blk_err;
		logic [31:0] blocks_now;
		logic [31:0] eb_now;
		logic defect_now;
		logic [47:0] eb_pct;
		logic [47:0] blk_pct;
		logic severe;
		logic errored;
		logic entering;
		logic uas_sec;
		logic avail_sec;
		logic quiet_sec;

		assign blk_err = blk_done[s] && (blk_bits[s] != '0);
		// include this cycle's event so nothing falls between seconds
		assign blocks_now = blocks_q + {31'h00000000, blk_done[s]};
		assign eb_now = eb_q + {31'h00000000, blk_err};
		assign defect_now = defect_q || sec_defect[s];

		// per-second accumulators, restarted on every tick
		always_ff @(posedge SYS_CLK or negedge RST_N) begin
			if (!RST_N) begin
				blocks_q <= 32'h00000000;
				eb_q <= 32'h00000000;
				defect_q <= 1'b0;
			end else if (tick) begin
				blocks_q <= 32'h00000000;
				eb_q <= 32'h00000000;
				defect_q <= 1'b0;
			end else begin
				blocks_q <= blocks_now;
				eb_q <= eb_now;
				defect_q <= defect_now;
			end
		end

		// integer compare avoids a divider: eb*100 >= blocks*30
		assign eb_pct = 48'(eb_now) * 48'(100);
		assign blk_pct = 48'(blocks_now) * 48'(pm_pkg::SES_PERCENT);
		assign severe = defect_now ||
			((blocks_now != 32'h00000000) && (eb_pct >= blk_pct));
		assign errored = (eb_now != 32'h00000000) || defect_now || severe;

		avail_tracker u_avail (
			.clk(SYS_CLK),
			.rst_n(RST_N),
			.tick(tick),
			.severe(severe),
			.unavailable(sec_unavail[s]),
			.entering(entering),
			.uas_second(uas_sec)
		);

		assign avail_sec = tick && !uas_sec;
		assign quiet_sec = avail_sec && !severe;

		// increments and backouts for this section's counters
		assign sec_inc[s][pm_pkg::F_ES] = {31'h00000000, avail_sec && errored};
		assign sec_inc[s][pm_pkg::F_SES] = {31'h00000000, avail_sec && severe};
		assign sec_inc[s][pm_pkg::F_UAS] = !uas_sec ? 32'h00000000 :
			(entering ? 32'(pm_pkg::UNAVAIL_RUN) : 32'h00000001);
		assign sec_inc[s][pm_pkg::F_BBE] = quiet_sec ? eb_now : 32'h00000000;
		assign sec_inc[s][pm_pkg::F_EB] = {31'h00000000, blk_err};
		assign sec_inc[s][pm_pkg::F_AVAIL_BLOCKS] = quiet_sec ? blocks_now : 32'h00000000;
		assign sec_inc[s][pm_pkg::F_AVAIL_SECONDS] = {31'h00000000, avail_sec};
		assign sec_dec[s][pm_pkg::F_ES] = 4'h0;
		assign sec_dec[s][pm_pkg::F_SES] = entering ? pm_pkg::SES_BACKOUT : 4'h0;
		assign sec_dec[s][pm_pkg::F_UAS] = 4'h0;
		assign sec_dec[s][pm_pkg::F_BBE] = 4'h0;
		assign sec_dec[s][pm_pkg::F_EB] = 4'h0;
		assign sec_dec[s][pm_pkg::F_AVAIL_BLOCKS] = 4'h0;
		assign sec_dec[s][pm_pkg::F_AVAIL_SECONDS] = entering ? pm_pkg::SES_BACKOUT : 4'h0;
	end

	assign MUX_UNAVAILABLE = sec_unavail[0];
	assign REGEN_UNAVAILABLE = sec_unavail[1];

	// line layer: coding violations per second
	logic [1:0] line_events;
	logic [31:0] line_cv_q;
	logic [31:0] line_cv_now;
	logic los_q;
	logic line_def_q;
	logic los_now;
	logic line_def_now;
	logic line_severe;
	logic line_errored;
	logic line_entering;
	logic line_uas_sec;
	logic line_avail_sec;

	assign line_events = {1'b0, BIPOLAR_VIOLATION_EVENT} + {1'b0, EXCESS_ZEROS_EVENT};
	assign line_cv_now = line_cv_q + {30'h00000000, line_events};
	assign los_now = los_q || LOSS_OF_SIGNAL;
	assign line_def_now = line_def_q || LINE_DEFECT;

	// defects are sticky within a second so a short dropout still counts
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			line_cv_q <= 32'h00000000;
			los_q <= 1'b0;
			line_def_q <= 1'b0;
		end else if (tick) begin
			line_cv_q <= 32'h00000000;
			los_q <= 1'b0;
			line_def_q <= 1'b0;
		end else begin
			line_cv_q <= line_cv_now;
			los_q <= los_now;
			line_def_q <= line_def_now;
		end
	end

	assign line_severe = (line_cv_now > 32'(pm_pkg::LINE_SES_LIMIT)) ||
		los_now || line_def_now;
	assign line_errored = (line_cv_now != 32'h00000000) || los_now;

	avail_tracker u_line_avail (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.tick(tick),
		.severe(line_severe),
		.unavailable(LINE_UNAVAILABLE),
		.entering(line_entering),
		.uas_second(line_uas_sec)
	);

	assign line_avail_sec = tick && !line_uas_sec;

	// section layer: parity errors per second
	logic [3:0] parity_now;
	logic [31:0] sect_cv_q;
	logic [31:0] sect_cv_now;
	logic framing_def_q;
	logic framing_def_now;
	logic sect_severe;
	logic sect_errored;

	// framer cannot legally report more than eight; clamp a bad value
	assign parity_now = !SECTION_FRAME_DONE ? 4'h0 :
		((SECTION_PARITY_ERRORS > pm_pkg::PARITY_MAX_PER_FRAME) ?
		pm_pkg::PARITY_MAX_PER_FRAME : SECTION_PARITY_ERRORS);
	assign sect_cv_now = sect_cv_q + {28'h0000000, parity_now};
	assign framing_def_now = framing_def_q || SEVERE_FRAMING_DEFECT;

	// current-second parity register and framing defect memory
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sect_cv_q <= 32'h00000000;
			framing_def_q <= 1'b0;
		end else if (tick) begin
			sect_cv_q <= 32'h00000000;
			framing_def_q <= 1'b0;
		end else begin
			sect_cv_q <= sect_cv_now;
			framing_def_q <= framing_def_now;
		end
	end

	// a threshold of zero would mark every second severe, so it acts as one
	assign sect_severe = ((sect_cv_now != 32'h00000000) &&
		(sect_cv_now >= {16'h0000, parity_k_q})) || framing_def_now || los_now;
	assign sect_errored = (sect_cv_now != 32'h00000000) || framing_def_now || los_now;

	// gather every counter's increment and backout
	always_comb begin
		for (int i = 0; i < NCNT; i++) begin
			cnt_inc[i] = 32'h00000000;
			cnt_dec[i] = 4'h0;
		end
		for (int f = 0; f < NF; f++) begin
			cnt_inc[pm_pkg::MUX_BASE + f] = sec_inc[0][f];
			cnt_dec[pm_pkg::MUX_BASE + f] = sec_dec[0][f];
			cnt_inc[pm_pkg::REGEN_BASE + f] = sec_inc[1][f];
			cnt_dec[pm_pkg::REGEN_BASE + f] = sec_dec[1][f];
		end
		cnt_inc[pm_pkg::LINE_CV] = {30'h00000000, line_events};
		cnt_inc[pm_pkg::LINE_ES] = {31'h00000000, line_avail_sec && line_errored};
		cnt_inc[pm_pkg::LINE_SES] = {31'h00000000, line_avail_sec && line_severe};
		cnt_dec[pm_pkg::LINE_SES] = line_entering ? pm_pkg::SES_BACKOUT : 4'h0;
		cnt_inc[pm_pkg::LINE_UAS] = !line_uas_sec ? 32'h00000000 :
			(line_entering ? 32'(pm_pkg::UNAVAIL_RUN) : 32'h00000001);
		cnt_inc[pm_pkg::SECT_CV] = {28'h0000000, parity_now};
		cnt_inc[pm_pkg::SECT_ES] = {31'h00000000, tick && sect_errored};
		cnt_inc[pm_pkg::FRAMING_SES] = {31'h00000000, tick && framing_def_now};
		cnt_inc[pm_pkg::SECT_SES] = {31'h00000000, tick && sect_severe};
	end

	// counter bank; a backout after a software clear floors at zero
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < NCNT; i++) begin
				cnt_q[i] <= 32'h00000000;
			end
		end else if (clear_all) begin
			for (int i = 0; i < NCNT; i++) begin
				cnt_q[i] <= 32'h00000000;
			end
		end else begin
			for (int i = 0; i < NCNT; i++) begin
				if ({28'h0000000, cnt_dec[i]} > cnt_q[i] + cnt_inc[i]) begin
					cnt_q[i] <= 32'h00000000;
				end else begin
					cnt_q[i] <= cnt_q[i] + cnt_inc[i] - {28'h0000000, cnt_dec[i]};
				end
			end
		end
	end

	// programmable parity threshold
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			parity_k_q <= pm_pkg::PARITY_K_RESET;
		end else if (REG_WR && (REG_ADDR == pm_pkg::ADDR_PARITY_K)) begin
			parity_k_q <= REG_WDATA[15:0];
		end
	end

	// read data registered, valid only in the cycle after the strobe
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= 32'h00000000;
		end else if (REG_RD) begin
			if (REG_ADDR < 5'(NCNT)) begin
				REG_RDATA <= cnt_q[REG_ADDR];
			end else begin
				case (REG_ADDR)
					pm_pkg::ADDR_PARITY_K: REG_RDATA <= {16'h0000, parity_k_q};
					pm_pkg::ADDR_STATUS: REG_RDATA <= {29'h00000000, LINE_UNAVAILABLE,
						REGEN_UNAVAILABLE, MUX_UNAVAILABLE};
					pm_pkg::ADDR_CUR_SECT_CV: REG_RDATA <= sect_cv_q;
					pm_pkg::ADDR_CUR_LINE_CV: REG_RDATA <= line_cv_q;
					default: REG_RDATA <= 32'h00000000;
				endcase
			end
		end else begin
			REG_RDATA <= 32'h00000000;
		end
	end
endmodule
`default_nettype wire

// >>> perf_monitor_properties.sv
// concurrent checks on the ports of perf_monitor, bound to every instance
// assumes one clock domain and the shortened second passed in by the bind
`timescale 1ns/1ps
`default_nettype none
module perf_monitor_checker #(
	parameter int unsigned SECOND_CYCLES = pm_pkg::SECOND_CYCLES
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic MUX_DEFECT,
	input wire logic REGEN_DEFECT,
	input wire logic LOSS_OF_SIGNAL,
	input wire logic [4:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_RDATA,
	input wire logic SECOND_TICK,
	input wire logic MUX_UNAVAILABLE,
	input wire logic REGEN_UNAVAILABLE,
	input wire logic LINE_UNAVAILABLE
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	int unsigned cycles_q;
	logic [3:0] ticks_q;
	// cycles since the last tick, an independent copy of the divider
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) cycles_q <= 0;
		else if (SECOND_TICK) cycles_q <= 0;
		else cycles_q <= cycles_q + 1;
	end
	// seconds since reset, saturating so it never wraps back below ten
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) ticks_q <= 4'h0;
		else if (SECOND_TICK && ticks_q != 4'hF) ticks_q <= ticks_q + 4'h1;
	end
	logic mux_seen_q;
	logic regen_seen_q;
	logic los_seen_q;
	// defect levels remembered until the tick that closes their second
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mux_seen_q <= 1'b0;
			regen_seen_q <= 1'b0;
			los_seen_q <= 1'b0;
		end else if (SECOND_TICK) begin
			mux_seen_q <= 1'b0;
			regen_seen_q <= 1'b0;
			los_seen_q <= 1'b0;
		end else begin
			mux_seen_q <= mux_seen_q || MUX_DEFECT;
			regen_seen_q <= regen_seen_q || REGEN_DEFECT;
			los_seen_q <= los_seen_q || LOSS_OF_SIGNAL;
		end
	end
	sequence s_k_write;
		REG_WR && REG_ADDR == pm_pkg::ADDR_PARITY_K;
	endsequence
	sequence s_k_read;
		REG_RD && REG_ADDR == pm_pkg::ADDR_PARITY_K;
	endsequence
	a_tick_spacing: assert property (SECOND_TICK == (cycles_q == SECOND_CYCLES - 1))
		else $error("tick spacing wrong");
	a_k_readback: assert property (s_k_write ##1 s_k_read |=>
		REG_RDATA[15:0] == $past(REG_WDATA[15:0], 2)) else $error("threshold readback wrong");
	a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 32'h0)
		else $error("read data outside read slot");
	a_status_read: assert property (REG_RD && REG_ADDR == pm_pkg::ADDR_STATUS |=>
		REG_RDATA == {29'h0, $past(LINE_UNAVAILABLE), $past(REGEN_UNAVAILABLE),
		$past(MUX_UNAVAILABLE)}) else $error("status word wrong");
	a_mux_at_tick: assert property ($changed(MUX_UNAVAILABLE) |-> $past(SECOND_TICK))
		else $error("mux availability moved off tick");
	a_regen_at_tick: assert property ($changed(REGEN_UNAVAILABLE) |-> $past(SECOND_TICK))
		else $error("regen availability moved off tick");
	a_line_at_tick: assert property ($changed(LINE_UNAVAILABLE) |-> $past(SECOND_TICK))
		else $error("line availability moved off tick");
	a_mux_stays: assert property (MUX_UNAVAILABLE && SECOND_TICK &&
		(mux_seen_q || MUX_DEFECT) |=> MUX_UNAVAILABLE)
		else $error("mux left unavailability on severe second");
	a_regen_stays: assert property (REGEN_UNAVAILABLE && SECOND_TICK &&
		(regen_seen_q || REGEN_DEFECT) |=> REGEN_UNAVAILABLE)
		else $error("regen left unavailability on severe second");
	a_line_stays: assert property (LINE_UNAVAILABLE && SECOND_TICK &&
		(los_seen_q || LOSS_OF_SIGNAL) |=> LINE_UNAVAILABLE)
		else $error("line left unavailability on severe second");
	a_enter_after_ten: assert property ($rose(MUX_UNAVAILABLE) || $rose(LINE_UNAVAILABLE)
		|-> ticks_q >= 4'hA) else $error("unavailable before ten seconds");
endmodule
bind perf_monitor perf_monitor_checker #(.SECOND_CYCLES(SECOND_CYCLES)) checker_inst (
	.SYS_CLK(SYS_CLK),
	.RST_N(RST_N),
	.MUX_DEFECT(MUX_DEFECT),
	.REGEN_DEFECT(REGEN_DEFECT),
	.LOSS_OF_SIGNAL(LOSS_OF_SIGNAL),
	.REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR),
	.REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA),
	.SECOND_TICK(SECOND_TICK),
	.MUX_UNAVAILABLE(MUX_UNAVAILABLE),
	.REGEN_UNAVAILABLE(REGEN_UNAVAILABLE),
	.LINE_UNAVAILABLE(LINE_UNAVAILABLE)
);
`default_nettype wire

// >>> framer_model.sv
// framer model: emits blocks, frames, line events and defect levels
// assumes go is one cycle and the count inputs hold until the next go
`timescale 1ns/1ps
`default_nettype none
module framer_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic [3:0] blocks,
	input wire logic [3:0] errs,
	input wire logic [3:0] pe,
	input wire logic [3:0] frames,
	input wire logic [4:0] viol,
	input wire logic [3:0] dfx,
	output logic blk_done,
	output logic [7:0] bit_err,
	output logic frame_done,
	output logic [3:0] par,
	output logic line_ev,
	output logic [3:0] dfx_o
);
	logic [3:0] nb_q, ne_q, nf_q;
	logic [4:0] nv_q;
	logic [5:0] act_q;
	// defects only inside the burst window, so they stay in one second
	assign dfx_o = (act_q != 6'h00) ? dfx : 4'h0;
	// one block, frame and line event per cycle until the counts run out
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{nb_q, ne_q, nf_q, nv_q, act_q} <= '0;
			{blk_done, bit_err, frame_done, par, line_ev} <= '0;
		end else if (go) begin
			{nb_q, ne_q, nf_q, nv_q, act_q} <= {blocks, errs, frames, viol, 6'h28};
		end else begin
			act_q <= act_q - {5'h0, act_q != 6'h00};
			nb_q <= nb_q - {3'h0, nb_q != 4'h0};
			ne_q <= ne_q - {3'h0, nb_q != 4'h0 && ne_q != 4'h0};
			nf_q <= nf_q - {3'h0, nf_q != 4'h0};
			nv_q <= nv_q - {4'h0, nv_q != 5'h00};
			blk_done <= nb_q != 4'h0;
			// idle data toggles so a stale value never passes for a count
			bit_err <= (nb_q == 4'h0) ? ~bit_err : {7'h00, ne_q != 4'h0};
			frame_done <= nf_q != 4'h0;
			par <= (nf_q == 4'h0) ? ~par : pe;
			line_ev <= nv_q != 5'h00;
		end
	end
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking bench for perf_monitor fed by the framer model
// assumes a 64-cycle second so availability runs stay short
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int unsigned SC = 64;
	localparam int chk_addr[5] = '{pm_pkg::F_SES, pm_pkg::LINE_SES, pm_pkg::F_UAS,
		pm_pkg::REGEN_BASE + pm_pkg::F_UAS, pm_pkg::LINE_UAS};
	// one second of stimulus beside the 22 counters it should leave
	typedef struct {
		int mb, me, pe, pf, lv, dfx;
		int e[15];
	} row_type;
	row_type rows[8] = '{
		'{10, 0, 0, 0, 0, 0, '{0, 0, 0, 0, 0, 10, 1, 0, 0, 0, 0, 0, 0, 0, 0}},
		'{10, 2, 1, 1, 22, 0, '{1, 0, 0, 2, 2, 10, 1, 44, 1, 0, 0, 1, 1, 0, 1}},
		'{10, 3, 9, 2, 23, 0, '{1, 1, 0, 0, 3, 0, 1, 46, 1, 1, 0, 16, 1, 0, 1}},
		'{10, 0, 0, 0, 0, 5, '{1, 1, 0, 0, 0, 0, 1, 0, 1, 1, 0, 0, 1, 0, 1}},
		'{0, 0, 0, 0, 0, 10, '{0, 0, 0, 0, 0, 0, 1, 0, 0, 1, 0, 0, 1, 1, 1}},
		'{0, 0, 1, 2, 0, 0, '{0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0, 2, 1, 0, 0}},
		'{0, 0, 1, 3, 0, 0, '{0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0, 3, 1, 0, 1}},
		'{0, 0, 0, 0, 0, 5, '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0}}};
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic go = 1'h0;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [4:0] reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [3:0] m_blocks = 4'h0, m_errs = 4'h0, m_pe = 4'h0, m_frames = 4'h0, m_dfx = 4'h0;
	logic [4:0] m_viol = 5'h00;
	logic blk_done, frame_done, line_ev, tick, mux_un, regen_un, line_un;
	logic [7:0] bit_err;
	logic [3:0] par, dfx;
	logic [31:0] rdata;
	int fails = 0;
	int checked = 0;
	// 10 MHz system clock
	always #50 clk = ~clk;
	framer_model partner (.clk(clk), .rst_n(rst_n), .go(go), .blocks(m_blocks), .errs(m_errs),
		.pe(m_pe), .frames(m_frames), .viol(m_viol), .dfx(m_dfx), .blk_done(blk_done),
		.bit_err(bit_err), .frame_done(frame_done), .par(par), .line_ev(line_ev), .dfx_o(dfx));
	// regen mirrors mux; both line events coincide so each counts twice
	perf_monitor #(.SECOND_CYCLES(SC)) uut (
		.SYS_CLK(clk),
		.RST_N(rst_n),
		.MUX_BLOCK_DONE(blk_done),
		.MUX_BLOCK_BIT_ERRORS(bit_err),
		.MUX_DEFECT(dfx[0]),
		.REGEN_BLOCK_DONE(blk_done),
		.REGEN_BLOCK_BIT_ERRORS(bit_err),
		.REGEN_DEFECT(dfx[0]),
		.SECTION_FRAME_DONE(frame_done),
		.SECTION_PARITY_ERRORS(par),
		.BIPOLAR_VIOLATION_EVENT(line_ev),
		.EXCESS_ZEROS_EVENT(line_ev),
		.LOSS_OF_SIGNAL(dfx[2]),
		.SEVERE_FRAMING_DEFECT(dfx[1]),
		.LINE_DEFECT(dfx[3]),
		.REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata),
		.REG_WR(reg_wr),
		.REG_RD(reg_rd),
		.REG_RDATA(rdata),
		.SECOND_TICK(tick),
		.MUX_UNAVAILABLE(mux_un),
		.REGEN_UNAVAILABLE(regen_un),
		.LINE_UNAVAILABLE(line_un)
	);
	task automatic summarize();
		if (fails == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	// data is sampled 10 ns after the edge, in the one slot where it stands
	task automatic rd(input logic [4:0] a, output logic [31:0] v);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		#10 v = rdata;
		@(posedge clk);
	endtask
	task automatic wait_tick();
		for (int n = 0; n < 2 * SC; n++) begin
			@(posedge clk);
			if (tick === 1'h1) return;
		end
		fails++;
		summarize();
	endtask
	task automatic drive(input row_type r);
		{m_blocks, m_errs, m_pe, m_frames} <= {4'(r.mb), 4'(r.me), 4'(r.pe), 4'(r.pf)};
		{m_viol, m_dfx} <= {5'(r.lv), 4'(r.dfx)};
		go <= 1'h1;
		@(posedge clk);
		go <= 1'h0;
	endtask
	// clear, play one second, then read every counter back
	task automatic run_row(input row_type r);
		logic [31:0] d;
		wait_tick();
		wr(pm_pkg::ADDR_CTRL, 32'h1);
		drive(r);
		// mid-second, after the burst: the running per-second counts
		repeat (30) @(posedge clk);
		rd(pm_pkg::ADDR_CUR_SECT_CV, d);
		chk("cur_sect_cv", 32'(r.e[11]), d);
		rd(pm_pkg::ADDR_CUR_LINE_CV, d);
		chk("cur_line_cv", 32'(r.e[7]), d);
		wait_tick();
		for (int a = 0; a < pm_pkg::NUM_COUNTERS; a++) begin
			rd(5'(a), d);
			chk($sformatf("counter_%0d", a), 32'(r.e[a >= 7 ? a - 7 : a]), d);
		end
	endtask
	// availability flags and second counts part way through the run
	task automatic unavail_check(input int s);
		logic [31:0] d;
		logic [2:0] st;
		st = (s == 10 || s == 20) ? 3'h7 : 3'h0;
		rd(pm_pkg::ADDR_STATUS, d);
		chk("status", {29'h0, st}, d);
		chk("unavail_pins", {29'h0, st}, {29'h0, line_un, regen_un, mux_un});
		for (int i = 0; i < 5; i++) begin
			rd(5'(chk_addr[i]), d);
			chk("run_count", 32'(i < 2 ? (s == 9 ? 9 : 0) : (s >= 10 ? s : 0)), d);
		end
	endtask
	// reset, table rows, then threshold and availability runs
	initial begin
		logic [31:0] d;
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		rd(5'h1F, d);
		chk("unmapped", 32'h0, d);
		rd(pm_pkg::ADDR_PARITY_K, d);
		chk("parity_k", 32'h1, d);
		for (int r = 0; r < 5; r++) begin
			run_row(rows[r]);
		end
		wr(pm_pkg::ADDR_PARITY_K, 32'h3);
		rd(pm_pkg::ADDR_PARITY_K, d);
		chk("parity_k", 32'h3, d);
		run_row(rows[5]);
		run_row(rows[6]);
		wait_tick();
		wr(pm_pkg::ADDR_CTRL, 32'h1);
		for (int s = 1; s <= 21; s++) begin
			if (s <= 11) begin
				drive(rows[7]);
			end
			wait_tick();
			if (s == 9 || s == 10 || s == 20 || s == 21) begin
				unavail_check(s);
			end
		end
		summarize();
	end
endmodule
`default_nettype wire
